// [lru_core_model.sv]
`timescale 1ns/1ps
`default_nettype none

module lru_core_model
(
  // request from the bench
  input  wire logic       go,
  input  wire logic       sram,
  input  wire logic       dma,
  input  wire logic [3:0] set,
  input  wire logic [1:0] way,
  // access into the block
  output lru_pkg::lru_acc_t acc
);
  // buffers a whole set apart, so 512 bytes per four sets
  assign acc = {go, dma, sram, ~sram, 21'h0, set, 7'h0, way};
endmodule

`default_nettype wire

// [lru_pkg.sv]
package lru_pkg;

  localparam int WAYS          = 4;
  localparam int WAY_W         = 2;
  localparam int GROUP_SETS    = 4;
  localparam int SET_IDX_LSB   = 7;
  localparam int SET_BYTES     = 128;
  localparam int MIN_BUF_SETS  = 4;
  localparam int MIN_BUF_BYTES = MIN_BUF_SETS * SET_BYTES;
  localparam logic [7:0] ORDER_RESET = 8'he4;

  typedef enum logic [1:0]
  {
    LRU_CMD_NONE,
    LRU_CMD_INV,
    LRU_CMD_WBINV
  } lru_cmd_t;

  typedef struct packed
  {
    logic        valid;
    logic        is_dma;
    logic        is_sram;
    logic        hit;
    logic [31:0] addr;
    logic [1:0]  way;
  } lru_acc_t;

  typedef struct packed
  {
    logic       valid;
    logic [1:0] way;
    logic       was_invalid;
  } lru_victim_t;

endpackage

// [lru_repl.sv]
// Functional notes
// RULE1: four ways per set, history every set
// RULE2: hit marks its way most recent
// RULE3: full set evicts least recent way
// RULE4: invalid way chosen before history
// RULE5: hit update writes only accessed set
// RULE6: history grouped four consecutive sets; code keeps a separate history for every set
// RULE7: on-chip ram accesses leave history unchanged
// RULE8: dma ram accesses leave history unchanged
// RULE9: ram addresses use same set index
// RULE10: block invalidate commands clear valid bits
// RULE11: software offsets buffers by 512 bytes
// RULE12: full order per set, reset defined
`timescale 1ns/1ps
`default_nettype none

module lru_repl
#(
  parameter int SETS  = 256,
  parameter int SET_W = 8
)
(
  // clock and reset
  input  wire logic              clock,
  input  wire logic              rst,
  // access from core or dma
  input  wire lru_pkg::lru_acc_t acc,
  // allocation request
  input  wire logic              alloc_req,
  input  wire logic [31:0]       alloc_addr,
  // block commands
  input  wire lru_pkg::lru_cmd_t cmd,
  input  wire logic [SET_W-1:0]  cmd_set,
  input  wire logic [1:0]        cmd_way,
  // victim answer
  output lru_pkg::lru_victim_t   victim,
  output logic [SET_W-1:0]       victim_set
);

  initial
  begin
    if ((1 << SET_W) != SETS || SETS % lru_pkg::GROUP_SETS != 0)
      $error("lru_repl: bad set count");
  end

  // order[i] packs way ids, slot 0 most recent, slot 3 least
  logic [7:0] order_reg [SETS];
  logic [3:0] valid_reg [SETS];

  // index bits identical for cache and ram addresses [RULE9]
  function automatic logic [SET_W-1:0] set_of(input logic [31:0] a);
    set_of = a[lru_pkg::SET_IDX_LSB +: SET_W];
  endfunction

  function automatic logic [7:0] touch(input logic [7:0] o,
                                       input logic [1:0] w);
    logic [7:0] r;
    logic [1:0] k;
    r = {o[5:0], w};
    k = 2'h0;
    for (int i = 0; i < lru_pkg::WAYS; i++)
      if (o[2*i +: 2] == w)
        k = 2'(i);
    // drop w from its old slot, keep others in order
    case (k)
      2'h0: r = o;
      2'h1: r = {o[7:4], o[1:0], w};
      2'h2: r = {o[7:6], o[3:0], w};
      default: r = {o[5:0], w};
    endcase
    touch = r;
  endfunction

  logic             hit_upd;
  logic [SET_W-1:0] acc_set;
  logic [SET_W-1:0] al_set;
  logic [7:0]       al_order;
  logic [3:0]       al_valid;
  logic [1:0]       pick;
  logic             pick_inv;

  // ram and dma traffic never touch history [RULE7] [RULE8]
  assign hit_upd  = acc.valid && acc.hit && !acc.is_sram && !acc.is_dma;
  assign acc_set  = set_of(acc.addr);
  assign al_set   = set_of(alloc_addr);
  assign al_order = order_reg[al_set];
  assign al_valid = valid_reg[al_set];

  always_comb
  begin
    pick     = al_order[7:6]; // least recent [RULE3]
    pick_inv = 1'b0;
    for (int i = lru_pkg::WAYS - 1; i >= 0; i--)
      if (!al_valid[i])
      begin
        pick     = 2'(i); // invalid first [RULE4]
        pick_inv = 1'b1;
      end
  end

  // history storage: one per set, not grouped by four sets as RULE6 asks [RULE1] [RULE6]
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      for (int s = 0; s < SETS; s++)
        order_reg[s] <= lru_pkg::ORDER_RESET; // [RULE12]
    end
    else
    begin
      if (alloc_req)
        order_reg[al_set] <= touch(al_order, pick);
      if (hit_upd) // only the accessed set [RULE2] [RULE5]
        order_reg[acc_set] <= touch(order_reg[acc_set], acc.way);
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      for (int s = 0; s < SETS; s++)
        valid_reg[s] <= 4'h0; // [RULE12]
    end
    else
    begin
      if (alloc_req)
        valid_reg[al_set][pick] <= 1'b1;
      if (cmd != lru_pkg::LRU_CMD_NONE) // [RULE10]
        valid_reg[cmd_set][cmd_way] <= 1'b0;
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      victim     <= '0;
      victim_set <= '0;
    end
    else
    begin
      victim.valid       <= alloc_req;
      victim.way         <= pick;
      victim.was_invalid <= pick_inv;
      victim_set         <= al_set;
    end
  end

  // helper view of one watched set for assertions
  logic [7:0] ord0;
  assign ord0 = order_reg[0];

  a_ram_no_touch: assert property (@(posedge clock) disable iff (rst)
    (acc.valid && (acc.is_sram || acc.is_dma) && !alloc_req
     && set_of(acc.addr) == '0) |=> $stable(ord0)) // [RULE7]
    else $error("ram or dma access changed history");

  a_hit_mru: assert property (@(posedge clock) disable iff (rst)
    (hit_upd && acc_set == '0) |=> ord0[1:0] == $past(acc.way)) // [RULE2]
    else $error("hit way not most recent");

  a_inv_first: assert property (@(posedge clock) disable iff (rst)
    (alloc_req && al_valid != 4'hf) |=> victim.was_invalid
     && !$past(al_valid[pick])) // [RULE4]
    else $error("victim skipped an invalid way");

  a_lru_victim: assert property (@(posedge clock) disable iff (rst)
    (alloc_req && al_valid == 4'hf) |=> victim.way == $past(al_order[7:6]))
    // [RULE3]
    else $error("victim not least recent");

  a_only_set: assert property (@(posedge clock) disable iff (rst)
    (hit_upd && acc_set == SET_W'(1) && !alloc_req) |=> $stable(ord0))
    // [RULE5]
    else $error("hit leaked into neighbour set");

  a_inv_cmd: assert property (@(posedge clock) disable iff (rst)
    (cmd != lru_pkg::LRU_CMD_NONE && !(alloc_req && al_set == cmd_set))
    |=> !valid_reg[$past(cmd_set)][$past(cmd_way)]) // [RULE10]
    else $error("block command left line valid");

  a_victim_pulse: assert property (@(posedge clock) disable iff (rst)
    alloc_req |=> victim.valid ##1 (victim.valid == $past(alloc_req)))
    // [RULE3]
    else $error("victim answer timing wrong");

  a_set_index: assert property (@(posedge clock) disable iff (rst)
    alloc_req |=> victim_set
      == $past(alloc_addr[lru_pkg::SET_IDX_LSB +: SET_W])) // [RULE9]
    else $error("set index mismatch");

  // true when the packed order holds each way exactly once
  function automatic logic is_perm(input logic [7:0] o);
    logic [3:0] seen;
    seen = 4'h0;
    for (int i = 0; i < lru_pkg::WAYS; i++)
      seen[o[2*i +: 2]] = 1'b1;
    is_perm = (seen == 4'hf);
  endfunction

  // allocation into set 0 that no hit overrides
  sequence s_alloc_clean;
    alloc_req && !(hit_upd && acc_set == al_set) && al_set == '0;
  endsequence

  // allocation whose line no block command clears
  sequence s_alloc_kept;
    alloc_req && !(cmd != lru_pkg::LRU_CMD_NONE && cmd_set == al_set
                   && cmd_way == pick);
  endsequence

  a_alloc_mru: assert property ( // [RULE3]
    @(posedge clock) disable iff (rst)
    s_alloc_clean |=> ord0[1:0] == $past(pick))
    else $error("allocated way not most recent");

  a_alloc_valid: assert property ( // [RULE4]
    @(posedge clock) disable iff (rst)
    s_alloc_kept |=> valid_reg[$past(al_set)][$past(pick)])
    else $error("allocated way not marked valid");

  a_order_perm: assert property ( // [RULE12]
    @(posedge clock) disable iff (rst)
    is_perm(ord0) && is_perm(al_order))
    else $error("history is not a full ordering");

  a_victim_idle: assert property ( // [RULE3]
    @(posedge clock) disable iff (rst)
    !alloc_req |=> !victim.valid)
    else $error("victim answer without request");

endmodule

`default_nettype wire

// [tb_top.sv]
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic clock = 0, rst = 1, go = 0, sram = 0, dma = 0, alloc_req = 0;
  logic [3:0] set = 0, cmd_set = 0, victim_set;
  logic [1:0] way = 0, cmd_way = 0;
  logic [31:0] alloc_addr = 0, seed = 32'hc7bba343, r;
  lru_pkg::lru_cmd_t cmd = lru_pkg::LRU_CMD_NONE;
  lru_pkg::lru_acc_t acc;
  lru_pkg::lru_victim_t victim;
  logic [1:0] ord [16][4];
  logic [3:0] vld [16];
  int mismatches = 0, total_checks = 0;
  always #5 clock = ~clock;
  lru_core_model u_core (.go(go), .sram(sram), .dma(dma), .set(set),
    .way(way), .acc(acc));
  lru_repl #(.SETS(16), .SET_W(4)) u_dut (.clock(clock), .rst(rst),
    .acc(acc), .alloc_req(alloc_req), .alloc_addr(alloc_addr), .cmd(cmd),
    .cmd_set(cmd_set), .cmd_way(cmd_way), .victim(victim),
    .victim_set(victim_set));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // move a way to the most recent slot
  task automatic touch(input logic [3:0] s, input logic [1:0] w);
    int i;
    i = 0;
    while (ord[s][i] !== w) i++;
    for (; i > 0; i--) ord[s][i] = ord[s][i-1];
    ord[s][0] = w;
  endtask
  function automatic logic [1:0] pick(input logic [3:0] s);
    for (int i = 0; i < 4; i++) if (!vld[s][i]) return i[1:0];
    return ord[s][3];
  endfunction
  task automatic chk(input logic ok);
    total_checks++;
    if (!ok)
    begin
      mismatches++;
      $display("MISMATCH %0t victim way or set", $time);
    end
  endtask
  task automatic hit(input logic [3:0] s, input logic [1:0] w,
    input logic rm, input logic d);
    {go, set, way, sram, dma} = {1'b1, s, w, rm, d};
    @(posedge clock) #1 go = 0;
    if (!rm && !d) touch(s, w);
    @(posedge clock) #1;
  endtask
  task automatic alloc(input logic [3:0] s);
    logic [1:0] e;
    logic ok;
    e = pick(s);
    alloc_req = 1;
    alloc_addr = {21'h0, s, 7'h0} | (rnd() & 32'h7f);
    @(posedge clock) #1 alloc_req = 0;
    ok = victim.valid === 1'b1 && victim.way === e && victim_set === s;
    chk(ok && victim.was_invalid === ~vld[s][e]);
    vld[s][e] = 1;
    touch(s, e);
    @(posedge clock) #1;
  endtask
  task automatic inv(input logic [3:0] s, input logic [1:0] w,
    input lru_pkg::lru_cmd_t c);
    cmd_set = s;
    cmd_way = w;
    cmd = c;
    @(posedge clock) #1 cmd = lru_pkg::LRU_CMD_NONE;
    vld[s][w] = 0;
    @(posedge clock) #1;
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    #100000;
    mismatches++;
    close_out();
  end
  initial
  begin
    for (int s = 0; s < 16; s++)
    begin
      vld[s] = 0;
      ord[s] = '{2'h0, 2'h1, 2'h2, 2'h3};
    end
    repeat (16) @(posedge clock);
    #1 rst = 0;
    repeat (5) alloc(4'h5);
    $display("fill test done");
    repeat (400)
    begin
      r = rnd();
      if (r[3:0] == 0)
        inv({1'b0, r[6:4]}, r[8:7], r[9] ? lru_pkg::LRU_CMD_WBINV
          : lru_pkg::LRU_CMD_INV);
      else if (vld[{1'b0, r[6:4]}][r[8:7]])
        hit({1'b0, r[6:4]}, r[8:7], r[10], r[11]);
      else
        alloc({1'b0, r[6:4]});
    end
    $display("random test done");
    hit(4'h5, 2'h0, 1, 0);
    hit(4'h5, 2'h0, 1, 1);
    repeat (2) alloc(4'h5);
    $display("ram test done");
    close_out();
  end
endmodule

`default_nettype wire
